// *** sgm_switchgear.v ***
// switchgear control manager: position decode, travel supervision, interlocks, trip manager
//
// Notes on behaviour
// [R1] closed-position auxiliary contact asserted means switchgear closed.
// [R2] open-position auxiliary contact asserted means switchgear open.
// [R3] readiness input asserted reports breaker ready, exported to other functions.
// [R4] withdrawn input asserted reports withdrawable breaker removed from service.
// [R5] separate configurable close and open travel times supervise each movement.
// [R6] any of three close interlocks asserted rejects a close command.
// [R7] any of three open interlocks asserted rejects an open command.
// [R8] any trip source becoming asserted issues an open command.
// [R9] trip open command held at least the configured minimum hold time.
// [R10] latched option keeps trip command asserted after source clears.
// [R11] acknowledge signal clears a latched trip command.
// [R12] trip manager only acts on switchgear with break capability.
// [R13] first switchgear must have break capability; other configuration refused.
// [R14] manual close and open executed only when switchgear is controlled.
// [R15] break capable but uncontrolled: trips accepted, manual commands refused.
// [R16] neither property: position reported only, never driven.
// [R17] controlled switchgear accepts external close and open request signals.
// [R18] each output relay driven by up to seven assignable signals.
// [R19] generator-to-grid sync: close abandoned if no synchronism within time.
// [R20] position code: 0 indeterminate, 1 open, 2 closed, 3 disturbed.
// [R21] both contacts disturbed; neither after travel expiry indeterminate.
// [R22] manual command ends at target position; timeout flags switching failure.
//
// Our own choices: the address map and the APB register port.
`include "sgm_regs.vh"
module sgm_switchgear #(
  parameter NRELAY = 2,
  parameter NSRC   = 7
) (
  input  wire              pclk,
  input  wire              presetn,
  input  wire [11:0]       paddr,
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [31:0]       pwdata,
  output reg  [31:0]       prdata,
  output reg               pready,
  output reg               pslverr,
  input  wire              aux_closed,
  input  wire              aux_open,
  input  wire              ready_input,
  input  wire              withdrawn_input,
  input  wire [2:0]        close_interlock_input,
  input  wire [2:0]        open_interlock_input,
  input  wire [3:0]        trip_source_input,
  input  wire              trip_acknowledge,
  input  wire              external_close_request,
  input  wire              external_open_request,
  input  wire              sync_ok,
  input  wire [3:0]        relay_aux,
  output reg               close_cmd,
  output reg               open_cmd,
  output reg               trip_cmd,
  output reg  [1:0]        position,
  output reg               breaker_ready,
  output reg               breaker_withdrawn,
  output reg               switch_fail,
  output reg               sync_fail,
  output reg  [NRELAY-1:0] relay_out
);
  // ==========================================================
  // states of the manual switching sequence
  localparam [3:0] ST_IDLE  = 4'b0001;
  localparam [3:0] ST_SYNC  = 4'b0010;
  localparam [3:0] ST_CLOSE = 4'b0100;
  localparam [3:0] ST_OPEN  = 4'b1000;

  // ==========================================================
  // pin synchronisers
  wire [17:0] pins_s;
  sgm_sync2 #(.W(18)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     ({aux_closed, aux_open, ready_input, withdrawn_input,
                close_interlock_input, open_interlock_input, trip_source_input,
                trip_acknowledge, external_close_request, external_open_request,
                sync_ok}),
    .dout    (pins_s)
  );
  wire       s_closed  = pins_s[17];
  wire       s_open    = pins_s[16];
  wire       s_ready   = pins_s[15];
  wire       s_wdrawn  = pins_s[14];
  wire [2:0] s_cil     = pins_s[13:11];
  wire [2:0] s_oil     = pins_s[10:8];
  wire [3:0] s_trip    = pins_s[7:4];
  wire       s_ack     = pins_s[3];
  wire       s_ext_cl  = pins_s[2];
  wire       s_ext_op  = pins_s[1];
  wire       s_sync    = pins_s[0];

  wire ms_tick;
  sgm_tick #(.CYCLES(`SGM_MS_CYCLES)) u_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (ms_tick)
  );

  // ==========================================================
  // registers
  reg [4:0]  ctrl;
  reg [15:0] move_on_ms;
  reg [15:0] move_off_ms;
  reg [15:0] trip_min_hold_time;
  reg [15:0] sync_supervision_time;
  reg [NSRC-1:0] relay_sel [0:NRELAY-1];
  reg        cfg_refused;
  reg        sw_close_req;
  reg        sw_open_req;
  reg        sw_ack;
  reg        sw_failclr;

  wire wr_acc = psel & penable & pwrite;
  wire rd_acc = psel & penable & ~pwrite;
  wire cfg_break = ctrl[`SGM_CTRL_BREAK];
  wire cfg_ctl   = ctrl[`SGM_CTRL_CONTROLLED];

  function mapped;
    input [11:0] a;
    begin
      mapped = (a == `SGM_CTRL_OFS) || (a == `SGM_MOVE_ON_OFS) ||
               (a == `SGM_MOVE_OFF_OFS) || (a == `SGM_TRIP_HOLD_OFS) ||
               (a == `SGM_SYNC_TIME_OFS) || (a == `SGM_CMD_OFS) ||
               (a == `SGM_STATUS_OFS) || (a == `SGM_RELAY0_OFS) ||
               (a == `SGM_RELAY1_OFS);
    end
  endfunction

  integer i;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl                  <= `SGM_CTRL_RESET;
      move_on_ms            <= `SGM_MOVE_ON_MS;
      move_off_ms           <= `SGM_MOVE_OFF_MS;
      trip_min_hold_time    <= `SGM_TRIP_HOLD_MS;
      sync_supervision_time <= `SGM_SYNC_MS;
      cfg_refused           <= 1'b0;
      sw_close_req          <= 1'b0;
      sw_open_req           <= 1'b0;
      sw_ack                <= 1'b0;
      sw_failclr            <= 1'b0;
      pready                <= 1'b0;
      pslverr               <= 1'b0;
      for (i = 0; i < NRELAY; i = i + 1) relay_sel[i] <= {NSRC{1'b0}};
    end else begin
      // one wait state: pready rises in the second access cycle
      pready       <= psel & penable & ~pready;
      pslverr      <= psel & penable & ~pready & ~mapped(paddr);
      sw_close_req <= 1'b0;
      sw_open_req  <= 1'b0;
      sw_ack       <= 1'b0;
      sw_failclr   <= 1'b0;
      if (wr_acc && pready) begin
        case (paddr)
          `SGM_CTRL_OFS: begin
            // first switchgear without break capability is refused
            if (pwdata[`SGM_CTRL_BREAK]) begin // R13
              ctrl        <= pwdata[4:0];
              cfg_refused <= 1'b0;
            end else begin
              cfg_refused <= 1'b1; // R13
            end
          end
          `SGM_MOVE_ON_OFS:   move_on_ms            <= pwdata[15:0];
          `SGM_MOVE_OFF_OFS:  move_off_ms           <= pwdata[15:0];
          `SGM_TRIP_HOLD_OFS: trip_min_hold_time    <= pwdata[15:0];
          `SGM_SYNC_TIME_OFS: sync_supervision_time <= pwdata[15:0];
          `SGM_CMD_OFS: begin
            sw_close_req <= pwdata[`SGM_CMD_CLOSE];
            sw_open_req  <= pwdata[`SGM_CMD_OPEN];
            sw_ack       <= pwdata[`SGM_CMD_ACK];
            sw_failclr   <= pwdata[`SGM_CMD_FAILCLR];
          end
          `SGM_RELAY0_OFS: relay_sel[0] <= pwdata[NSRC-1:0];
          `SGM_RELAY1_OFS: relay_sel[1] <= pwdata[NSRC-1:0];
          default: ;
        endcase
      end
    end
  end

  // ==========================================================
  // position decode
  reg [1:0]  pos_raw;
  reg        timed_out;
  always @* begin
    if (s_closed && s_open)
      pos_raw = `SGM_POS_DISTURB; // R21
    else if (s_closed)
      pos_raw = `SGM_POS_CLOSED; // R1 R20
    else if (s_open)
      pos_raw = `SGM_POS_OPEN; // R2 R20
    else if (timed_out)
      pos_raw = `SGM_POS_INDET; // R21
    else
      pos_raw = position;
  end

  // ==========================================================
  // trip manager
  reg [3:0]  trip_prev;
  reg [15:0] hold_cnt;
  reg        trip_latch;
  wire trip_rise = |(s_trip & ~trip_prev); // R8
  wire trip_allowed = cfg_break; // R12 R15
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trip_prev  <= 4'h0;
      hold_cnt   <= 16'h0000;
      trip_latch <= 1'b0;
      trip_cmd   <= 1'b0;
    end else begin
      trip_prev <= s_trip;
      if (trip_rise && trip_allowed) begin
        hold_cnt   <= trip_min_hold_time; // R9
        trip_latch <= ctrl[`SGM_CTRL_LATCHED]; // R10
        trip_cmd   <= 1'b1; // R8
      end else begin
        // acknowledge only clears once source is gone; new trips win
        if ((s_ack || sw_ack) && !(|s_trip))
          trip_latch <= 1'b0; // R11
        if (ms_tick && hold_cnt != 16'h0000)
          hold_cnt <= hold_cnt - 16'h0001;
        trip_cmd <= trip_allowed &
                    ((hold_cnt != 16'h0000) | trip_latch | (|s_trip)); // R9 R10
      end
    end
  end

  // ==========================================================
  // manual and external switching sequence
  reg [3:0]  state;
  reg [15:0] move_cnt;
  reg        ext_cl_prev;
  reg        ext_op_prev;
  wire close_req = sw_close_req | (s_ext_cl & ~ext_cl_prev); // R17
  wire open_req  = sw_open_req | (s_ext_op & ~ext_op_prev); // R17
  wire close_ok  = cfg_ctl & ~(|s_cil); // R6 R14
  wire open_ok   = cfg_ctl & ~(|s_oil); // R7 R14
  wire sync_mode = ctrl[`SGM_CTRL_SYNC_EN] & ctrl[`SGM_CTRL_GEN2GRID] & cfg_break;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state       <= ST_IDLE;
      move_cnt    <= 16'h0000;
      ext_cl_prev <= 1'b0;
      ext_op_prev <= 1'b0;
      close_cmd   <= 1'b0;
      open_cmd    <= 1'b0;
      switch_fail <= 1'b0;
      sync_fail   <= 1'b0;
      timed_out   <= 1'b0;
      position    <= `SGM_POS_INDET;
    end else begin
      ext_cl_prev <= s_ext_cl;
      ext_op_prev <= s_ext_op;
      position    <= pos_raw;
      if (sw_failclr) begin
        switch_fail <= 1'b0;
        sync_fail   <= 1'b0;
      end
      if (ms_tick && move_cnt != 16'h0000)
        move_cnt <= move_cnt - 16'h0001;
      case (state)
        ST_IDLE: begin
          close_cmd <= 1'b0;
          open_cmd  <= 1'b0;
          if (open_req && open_ok) begin
            state    <= ST_OPEN;
            move_cnt <= move_off_ms; // R5
            open_cmd <= 1'b1;
            // cleared only by a new move: a contact dropping late still reads indeterminate
            timed_out <= 1'b0;
          end else if (close_req && close_ok && sync_mode) begin
            state    <= ST_SYNC;
            move_cnt <= sync_supervision_time; // R19
          end else if (close_req && close_ok) begin
            state     <= ST_CLOSE;
            move_cnt  <= move_on_ms; // R5
            close_cmd <= 1'b1;
            timed_out <= 1'b0;
          end
        end
        ST_SYNC: begin
          if (s_sync && close_ok) begin
            state     <= ST_CLOSE;
            move_cnt  <= move_on_ms;
            close_cmd <= 1'b1;
            timed_out <= 1'b0;
          end else if (move_cnt == 16'h0000 || !close_ok) begin
            state     <= ST_IDLE;
            sync_fail <= 1'b1; // R19
          end
        end
        ST_CLOSE: begin
          if (s_closed && !s_open) begin
            state     <= ST_IDLE; // R22
            close_cmd <= 1'b0;
          end else if (move_cnt == 16'h0000) begin
            state       <= ST_IDLE;
            close_cmd   <= 1'b0;
            switch_fail <= 1'b1; // R22
            timed_out   <= 1'b1; // R21
          end
        end
        ST_OPEN: begin
          if (s_open && !s_closed) begin
            state    <= ST_IDLE; // R22
            open_cmd <= 1'b0;
          end else if (move_cnt == 16'h0000) begin
            state       <= ST_IDLE;
            open_cmd    <= 1'b0;
            switch_fail <= 1'b1; // R22
            timed_out   <= 1'b1; // R21
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // indications and relay matrix
  // relay sources: close, open or trip, trip, then four free aux signals
  wire [NSRC-1:0] relay_src = {relay_aux, trip_cmd, open_cmd | trip_cmd, close_cmd};
  integer r;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      breaker_ready     <= 1'b0;
      breaker_withdrawn <= 1'b0;
      relay_out         <= {NRELAY{1'b0}};
    end else begin
      breaker_ready     <= s_ready; // R3
      breaker_withdrawn <= s_wdrawn; // R4
      // monitor-only switchgear never drives the close, open or trip source; the aux sources pass in every configuration
      for (r = 0; r < NRELAY; r = r + 1)
        relay_out[r] <= |(relay_sel[r] & relay_src); // R18 R16
    end
  end

  // ==========================================================
  // read mux
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_acc && !pready) begin
      case (paddr)
        `SGM_CTRL_OFS:      prdata <= {27'h0000000, ctrl};
        `SGM_MOVE_ON_OFS:   prdata <= {16'h0000, move_on_ms};
        `SGM_MOVE_OFF_OFS:  prdata <= {16'h0000, move_off_ms};
        `SGM_TRIP_HOLD_OFS: prdata <= {16'h0000, trip_min_hold_time};
        `SGM_SYNC_TIME_OFS: prdata <= {16'h0000, sync_supervision_time};
        `SGM_STATUS_OFS:    prdata <= {18'h00000, cfg_refused, state, sync_fail,
                                       switch_fail, trip_cmd, open_cmd, close_cmd,
                                       breaker_withdrawn, breaker_ready, position};
        `SGM_RELAY0_OFS:    prdata <= {{(32-NSRC){1'b0}}, relay_sel[0]};
        `SGM_RELAY1_OFS:    prdata <= {{(32-NSRC){1'b0}}, relay_sel[1]};
        default:            prdata <= 32'h00000000;
      endcase
    end
  end
endmodule

// *** sgm_regs.vh ***
// register map, field positions, reset values and timing constants of the switchgear manager
`ifndef SGM_REGS_VH
`define SGM_REGS_VH
// ==========================================================
// register byte offsets
`define SGM_CTRL_OFS        12'h000
`define SGM_MOVE_ON_OFS     12'h004
`define SGM_MOVE_OFF_OFS    12'h008
`define SGM_TRIP_HOLD_OFS   12'h00C
`define SGM_SYNC_TIME_OFS   12'h010
`define SGM_CMD_OFS         12'h014
`define SGM_STATUS_OFS      12'h018
`define SGM_RELAY0_OFS      12'h020
`define SGM_RELAY1_OFS      12'h024
// ==========================================================
// control register fields
`define SGM_CTRL_BREAK      0
`define SGM_CTRL_CONTROLLED 1
`define SGM_CTRL_LATCHED    2
`define SGM_CTRL_SYNC_EN    3
`define SGM_CTRL_GEN2GRID   4
`define SGM_CTRL_RESET      5'h01
// command register fields (write one to request)
`define SGM_CMD_CLOSE       0
`define SGM_CMD_OPEN        1
`define SGM_CMD_ACK         2
`define SGM_CMD_FAILCLR     3
// ==========================================================
// position codes
`define SGM_POS_INDET       2'h0
`define SGM_POS_OPEN        2'h1
`define SGM_POS_CLOSED      2'h2
`define SGM_POS_DISTURB     2'h3
// ==========================================================
// timing: times in ms, clock period in ns
`define SGM_CLK_PERIOD_NS   10
`define SGM_MOVE_ON_MS      16'h0064
`define SGM_MOVE_OFF_MS     16'h0064
`define SGM_TRIP_HOLD_MS    16'h00C8
`define SGM_SYNC_MS         16'h03E8
`define SGM_MS_CYCLES       (1000000 / `SGM_CLK_PERIOD_NS)
`endif

// *** sgm_sync2.v ***
// two-flip-flop synchroniser for a vector of pin inputs
module sgm_sync2 #(
  parameter W = 1
) (
  input  wire         pclk,
  input  wire         presetn,
  input  wire [W-1:0] din,
  output reg  [W-1:0] dout
);
  reg [W-1:0] meta;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= {W{1'b0}};
      dout <= {W{1'b0}};
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule

// *** sgm_tick.v ***
// millisecond tick generator from the processing clock
module sgm_tick #(
  parameter CYCLES = 100000
) (
  input  wire pclk,
  input  wire presetn,
  output reg  tick
);
  reg [31:0] cnt;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt  <= 32'h00000000;
      tick <= 1'b0;
    end else if (cnt == CYCLES - 1) begin
      cnt  <= 32'h00000000;
      tick <= 1'b1;
    end else begin
      cnt  <= cnt + 32'h00000001;
      tick <= 1'b0;
    end
  end
endmodule

// *** sgm_switchgear_asserts.sv ***
// concurrent checks on the ports of the switchgear manager
module sgm_switchgear_asserts (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       aux_closed,
  input wire logic       aux_open,
  input wire logic       ready_input,
  input wire logic       withdrawn_input,
  input wire logic [2:0] close_interlock_input,
  input wire logic [2:0] open_interlock_input,
  input wire logic [3:0] trip_source_input,
  input wire logic       close_cmd,
  input wire logic       open_cmd,
  input wire logic       trip_cmd,
  input wire logic [1:0] position,
  input wire logic       breaker_ready,
  input wire logic       breaker_withdrawn
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================
  // position and pin status
  a_pos_closed: assert property ((aux_closed && !aux_open)[*5] |-> position == 2'h2)
    else $error("closed contact not reported as closed");
  a_pos_open: assert property ((aux_open && !aux_closed)[*5] |-> position == 2'h1)
    else $error("open contact not reported as open");
  a_pos_disturb: assert property ((aux_open && aux_closed)[*5] |-> position == 2'h3)
    else $error("both contacts not reported as disturbed");
  a_ready_shown: assert property (ready_input[*4] |-> breaker_ready)
    else $error("ready input not reported");
  a_withdrawn_shown: assert property (withdrawn_input[*4] |-> breaker_withdrawn)
    else $error("withdrawn input not reported");
  // ==========================================================
  // commands
  a_close_locked: assert property ((close_interlock_input != 3'h0)[*5] |-> !$rose(close_cmd))
    else $error("close command issued while interlocked");
  a_open_locked: assert property ((open_interlock_input != 3'h0)[*5] |-> !$rose(open_cmd))
    else $error("open command issued while interlocked");
  a_trip_cause: assert property ($rose(trip_cmd) |-> $past(trip_source_input, 3) != 4'h0)
    else $error("trip command without a trip source");
  a_trip_stays: assert property (trip_cmd && trip_source_input != 4'h0 |=> trip_cmd)
    else $error("trip command dropped while source active");
  // ==========================================================
  // register bus handshake
  a_apb_wait: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
    else $error("access phase not answered after one wait state");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
endmodule
bind sgm_switchgear sgm_switchgear_asserts sgm_switchgear_asserts_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .aux_closed(aux_closed), .aux_open(aux_open),
  .ready_input(ready_input), .withdrawn_input(withdrawn_input),
  .close_interlock_input(close_interlock_input), .open_interlock_input(open_interlock_input),
  .trip_source_input(trip_source_input), .close_cmd(close_cmd), .open_cmd(open_cmd),
  .trip_cmd(trip_cmd), .position(position), .breaker_ready(breaker_ready),
  .breaker_withdrawn(breaker_withdrawn));

// *** sgm_gear_model.sv ***
// behavioural breaker with auxiliary contacts that travel on coil commands
module sgm_gear_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic close_cmd,
  input  wire logic open_cmd,
  input  wire logic trip_cmd,
  input  wire logic force_both,
  output logic      aux_closed,
  output logic      aux_open
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt;
  // contacts break first and make later, so a gap with neither is seen
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aux_closed <= 1'b0;
      aux_open <= 1'b1;
      cnt <= 4'h0;
    end else if (force_both) begin
      aux_closed <= 1'b1;
      aux_open <= 1'b1;
    end else if ((open_cmd || trip_cmd) && !aux_open) begin
      aux_closed <= 1'b0;
      cnt <= cnt + 4'h1;
      if (cnt == 4'h5) aux_open <= 1'b1;
    end else if (close_cmd && !aux_closed) begin
      aux_open <= 1'b0;
      cnt <= cnt + 4'h1;
      if (cnt == 4'h5) aux_closed <= 1'b1;
    end else begin
      cnt <= 4'h0;
    end
  end
endmodule

// *** test_switchgear_control_manager.sv ***
// self-checking bench of the switchgear manager
`include "sgm_regs.vh"
module test_switchgear_control_manager;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, force_both = 0;
  logic        ready_input = 0, withdrawn_input = 0, trip_acknowledge = 0, sync_ok = 0;
  logic        external_close_request = 0, external_open_request = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [2:0]  close_interlock_input = 0, open_interlock_input = 0;
  logic [3:0]  trip_source_input = 0;
  logic [3:0]  relay_aux = 0;
  logic [1:0]  position, relay_out;
  logic        pready, pslverr, er, aux_closed, aux_open, close_cmd, open_cmd, trip_cmd;
  logic        breaker_ready, breaker_withdrawn, switch_fail, sync_fail;
  int          errors = 0, checks = 0, i;
  always #5 pclk = ~pclk;
  sgm_switchgear sgm_switchgear_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .aux_closed(aux_closed), .aux_open(aux_open), .ready_input(ready_input),
    .withdrawn_input(withdrawn_input), .close_interlock_input(close_interlock_input),
    .open_interlock_input(open_interlock_input), .trip_source_input(trip_source_input),
    .trip_acknowledge(trip_acknowledge), .external_close_request(external_close_request),
    .external_open_request(external_open_request), .sync_ok(sync_ok), .relay_aux(relay_aux),
    .close_cmd(close_cmd), .open_cmd(open_cmd), .trip_cmd(trip_cmd), .position(position),
    .breaker_ready(breaker_ready), .breaker_withdrawn(breaker_withdrawn),
    .switch_fail(switch_fail), .sync_fail(sync_fail), .relay_out(relay_out));
  sgm_gear_model sgm_gear_model_i (.pclk(pclk), .presetn(presetn), .close_cmd(close_cmd),
    .open_cmd(open_cmd), .trip_cmd(trip_cmd), .force_both(force_both),
    .aux_closed(aux_closed), .aux_open(aux_open));
  // ==========================================================
  // shared tasks
  task automatic print_verdict;
    if (errors == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("pready", 1, pready);
  endtask
  // bounded wait; the caller judges the level afterwards
  task automatic wait_lvl(ref logic s, input logic v, input int lim);
    for (int k = 0; k < lim && s !== v; k++) @(posedge pclk);
  endtask
  task automatic until_pos(input logic [1:0] p);
    for (int k = 0; k < 60 && position !== p; k++) @(posedge pclk);
    chk("position", p, position);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_regs;
    apb(0, `SGM_CTRL_OFS, 0);
    chk("ctrl", 32'h1, rd);
    apb(1, `SGM_MOVE_ON_OFS, 32'h7);
    apb(0, `SGM_MOVE_ON_OFS, 0);
    chk("move_on", 32'h7, rd);
    apb(0, `SGM_MOVE_OFF_OFS, 0);
    chk("move_off", `SGM_MOVE_OFF_MS, rd);
    apb(0, 12'h01C, 0);
    chk("unmapped_err", 1, er);
    chk("unmapped_rd", 0, rd);
    apb(1, `SGM_TRIP_HOLD_OFS, 0);
    apb(1, `SGM_CTRL_OFS, 32'h2);
    apb(0, `SGM_CTRL_OFS, 0);
    chk("ctrl_kept", 32'h1, rd);
    apb(0, `SGM_STATUS_OFS, 0);
    chk("cfg_refused", 1, rd[13]);
  endtask
  task automatic t_manual_off;
    apb(1, `SGM_CMD_OFS, 32'h1);
    external_close_request <= 1'b1;
    cyc(20);
    chk("uncontrolled_close", 0, close_cmd);
    external_close_request <= 1'b0;
    until_pos(2'h1);
  endtask
  task automatic t_switching;
    apb(1, `SGM_CTRL_OFS, 32'h3);
    for (i = 0; i < 3; i++) begin
      close_interlock_input <= 3'h1 << i;
      cyc(4);
      apb(1, `SGM_CMD_OFS, 32'h1);
      cyc(10);
      chk("close_locked", 0, close_cmd);
      close_interlock_input <= 3'h0;
      open_interlock_input <= 3'h1 << i;
      cyc(4);
      external_open_request <= 1'b1;
      cyc(10);
      chk("open_locked", 0, open_cmd);
      external_open_request <= 1'b0;
      open_interlock_input <= 3'h0;
      cyc(4);
    end
    apb(1, `SGM_CMD_OFS, 32'h1);
    wait_lvl(close_cmd, 1, 20);
    chk("close_cmd", 1, close_cmd);
    until_pos(2'h2);
    wait_lvl(close_cmd, 0, 20);
    chk("close_ended", 0, close_cmd);
    external_open_request <= 1'b1;
    wait_lvl(open_cmd, 1, 20);
    chk("ext_open", 1, open_cmd);
    external_open_request <= 1'b0;
    until_pos(2'h1);
    wait_lvl(open_cmd, 0, 20);
    chk("open_ended", 0, open_cmd);
    external_close_request <= 1'b1;
    wait_lvl(close_cmd, 1, 20);
    chk("ext_close", 1, close_cmd);
    external_close_request <= 1'b0;
    until_pos(2'h2);
  endtask
  task automatic t_pins;
    apb(1, `SGM_RELAY0_OFS, 32'h8);
    relay_aux <= 4'h1;
    ready_input <= 1'b1;
    withdrawn_input <= 1'b1;
    cyc(5);
    chk("relay0", 1, relay_out[0]);
    chk("ready", 1, breaker_ready);
    chk("withdrawn", 1, breaker_withdrawn);
    apb(0, `SGM_STATUS_OFS, 0);
    chk("status_pins", 2'h3, rd[3:2]);
    relay_aux <= 4'h0;
    ready_input <= 1'b0;
    withdrawn_input <= 1'b0;
    cyc(5);
    chk("relay0_off", 0, relay_out[0]);
    chk("pins_off", 2'h0, {breaker_ready, breaker_withdrawn});
  endtask
  task automatic t_fail;
    apb(1, `SGM_MOVE_OFF_OFS, 0);
    apb(1, `SGM_CMD_OFS, 32'h2);
    wait_lvl(switch_fail, 1, 20);
    chk("switch_fail", 1, switch_fail);
    until_pos(2'h0);
    apb(1, `SGM_CTRL_OFS, 32'h1B);
    apb(1, `SGM_SYNC_TIME_OFS, 0);
    apb(1, `SGM_CMD_OFS, 32'h1);
    wait_lvl(sync_fail, 1, 20);
    chk("sync_fail", 1, sync_fail);
    chk("sync_no_close", 0, close_cmd);
    apb(1, `SGM_CMD_OFS, 32'h8);
    cyc(3);
    chk("fail_clear", 0, {switch_fail, sync_fail});
  endtask
  task automatic t_trip;
    apb(1, `SGM_CTRL_OFS, 32'h5);
    apb(1, `SGM_RELAY1_OFS, 32'h4);
    trip_source_input <= 4'h4;
    wait_lvl(trip_cmd, 1, 20);
    chk("trip_cmd", 1, trip_cmd);
    cyc(2);
    chk("relay1_trip", 1, relay_out[1]);
    until_pos(2'h1);
    trip_source_input <= 4'h0;
    cyc(30);
    chk("trip_latched", 1, trip_cmd);
    trip_acknowledge <= 1'b1;
    wait_lvl(trip_cmd, 0, 100);
    chk("trip_acked", 0, trip_cmd);
    trip_acknowledge <= 1'b0;
  endtask
  task automatic t_disturb;
    force_both <= 1'b1;
    until_pos(2'h3);
    force_both <= 1'b0;
  endtask
  // ==========================================================
  // main sequence and watchdog
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_manual_off;
    t_switching;
    t_pins;
    t_fail;
    t_trip;
    t_disturb;
    print_verdict;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    print_verdict;
  end
endmodule
